// >>> core/asbl_consts.vh
// Purpose: shared constants for the async sram host controller
// Assumes: core clock of 20 MHz, 50 ns period
// Notes: times in ns, counts derived from them
`ifndef ASBL_CONSTS_VH
`define ASBL_CONSTS_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define ASBL_ADDR_W 18
`define ASBL_DATA_W 16
`define ASBL_WORDS 262144
`define ASBL_LO_LSB 0
`define ASBL_HI_LSB 8

// ----------------------------------------
// timing
// ----------------------------------------
`define ASBL_CLK_PERIOD_NS 50
`define ASBL_WRITE_PULSE_MIN_NS 15
`define ASBL_ADDR_SETUP_MIN_NS 0
`define ASBL_WRITE_RECOVERY_MIN_NS 0
`define ASBL_SELECT_TO_WRITE_END_NS 14
`define ASBL_READ_ACCESS_NS 20
`define ASBL_CYC_UP(t) ((((t) + `ASBL_CLK_PERIOD_NS - 1) / `ASBL_CLK_PERIOD_NS) < 1 ? 1 : \
    (((t) + `ASBL_CLK_PERIOD_NS - 1) / `ASBL_CLK_PERIOD_NS))
`define ASBL_WRITE_PULSE_CYC `ASBL_CYC_UP(`ASBL_WRITE_PULSE_MIN_NS)
`define ASBL_ADDR_SETUP_CYC `ASBL_CYC_UP(`ASBL_ADDR_SETUP_MIN_NS)
`define ASBL_WRITE_RECOVERY_CYC `ASBL_CYC_UP(`ASBL_WRITE_RECOVERY_MIN_NS)
`define ASBL_READ_ACCESS_CYC `ASBL_CYC_UP(`ASBL_READ_ACCESS_NS)
`define ASBL_SELECT_TO_WRITE_END_CYC `ASBL_CYC_UP(`ASBL_SELECT_TO_WRITE_END_NS)
// extra read wait covering the data synchroniser
`define ASBL_SYNC_WAIT_CYC 3

// ----------------------------------------
// state codes
// ----------------------------------------
`define ASBL_ST_IDLE 3'h0
`define ASBL_ST_SETUP 3'h1
`define ASBL_ST_WPULSE 3'h2
`define ASBL_ST_WREC 3'h3
`define ASBL_ST_RACC 3'h4
`define ASBL_ST_RDONE 3'h5

`endif

// >>> core/asbl_sync3.v
// Purpose: three-flop synchroniser for pin inputs
// Assumes: one clock domain
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module asbl_sync3 #(
    parameter W = 16
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // data
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;

    // ----------------------------------------
    // stages
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            s1 <= {W{1'b0}};
            s2 <= {W{1'b0}};
            s3 <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            // each pin settles on its own, an idle lane cannot stall the others
            dout <= (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
        end
    end

endmodule

`default_nettype wire

// >>> core/asbl_host.v
// Purpose: host controller driving an async 256k x 16 static ram
// Assumes: request held until ack pulse; pins sampled through sync
// Notes: one access at a time, data bus enable high while driving
`timescale 1ns/1ps
`default_nettype none
`include "asbl_consts.vh"

module asbl_host #(
    parameter ADDR_W = `ASBL_ADDR_W,
    parameter DATA_W = `ASBL_DATA_W,
    parameter WPULSE_CYC = `ASBL_WRITE_PULSE_CYC,
    parameter SETUP_CYC = `ASBL_ADDR_SETUP_CYC,
    parameter WREC_CYC = `ASBL_WRITE_RECOVERY_CYC,
    parameter RACC_CYC = `ASBL_READ_ACCESS_CYC
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // user request side
    input wire req_valid,
    input wire req_write,
    input wire [ADDR_W-1:0] req_addr,
    input wire [DATA_W-1:0] req_wdata,
    input wire [1:0] req_lane_en,
    output reg req_ready,
    output reg rsp_valid,
    output reg [DATA_W-1:0] rsp_rdata,
    // memory pins
    output reg [ADDR_W-1:0] addr_lines,
    output reg device_select_n,
    output reg write_strobe_n,
    output reg output_gate_n,
    output reg low_byte_en_n,
    output reg high_byte_en_n,
    input wire [DATA_W-1:0] shared_data_lines_i,
    output reg [DATA_W-1:0] shared_data_lines_o,
    output reg shared_data_lines_oe
);

    localparam CNT_W = 8;

    // ----------------------------------------
    // state codes
    // ----------------------------------------
    localparam [2:0] ST_IDLE = `ASBL_ST_IDLE;
    localparam [2:0] ST_SETUP = `ASBL_ST_SETUP;
    localparam [2:0] ST_WPULSE = `ASBL_ST_WPULSE;
    localparam [2:0] ST_WREC = `ASBL_ST_WREC;
    localparam [2:0] ST_RACC = `ASBL_ST_RACC;
    localparam [2:0] ST_RDONE = `ASBL_ST_RDONE;

    // ----------------------------------------
    // cycle counts
    // ----------------------------------------
    localparam SEL_END_CYC = `ASBL_SELECT_TO_WRITE_END_CYC;
    localparam SYNC_CYC = `ASBL_SYNC_WAIT_CYC;
    localparam [CNT_W-1:0] SETUP_CNT = SETUP_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] WPULSE_CNT = WPULSE_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] SEL_END_CNT = SEL_END_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] WHOLD_CNT = (WPULSE_CNT > SEL_END_CNT) ? WPULSE_CNT : SEL_END_CNT;
    localparam [CNT_W-1:0] WREC_CNT = WREC_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] RACC_CNT = RACC_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] SYNC_CNT = SYNC_CYC[CNT_W-1:0];

    reg [2:0] state;
    reg [CNT_W-1:0] cnt;
    reg [DATA_W-1:0] lane_mask;
    wire [DATA_W-1:0] rd_sync;

    // ----------------------------------------
    // read data synchroniser
    // ----------------------------------------
    asbl_sync3 #(
        .W(DATA_W)
    ) i_asbl_sync3 (
        .core_clk(core_clk),
        .rst(rst),
        .din(shared_data_lines_i),
        .dout(rd_sync)
    );

    // ----------------------------------------
    // read lane mask
    // ----------------------------------------
    always @* begin
        lane_mask = {DATA_W{1'b0}};
        lane_mask[`ASBL_LO_LSB +: 8] = {8{~low_byte_en_n}};
        lane_mask[`ASBL_HI_LSB +: 8] = {8{~high_byte_en_n}};
    end

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= {CNT_W{1'b0}};
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {DATA_W{1'b0}};
            addr_lines <= {ADDR_W{1'b0}};
            device_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_gate_n <= 1'b1;
            low_byte_en_n <= 1'b1;
            high_byte_en_n <= 1'b1;
            shared_data_lines_o <= {DATA_W{1'b0}};
            shared_data_lines_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid && !req_ready) begin
                        // address placed before select falls on write, in the same cycle on read
                        addr_lines <= req_addr;
                        low_byte_en_n <= ~req_lane_en[0];
                        high_byte_en_n <= ~req_lane_en[1];
                        cnt <= SETUP_CNT;
                        if (req_write) begin
                            // address set up with strobe high first
                            write_strobe_n <= 1'b1;
                            output_gate_n <= 1'b1;
                            shared_data_lines_o <= req_wdata;
                            shared_data_lines_oe <= 1'b1;
                            state <= ST_SETUP;
                        end else begin
                            // strobe high, bus released for read
                            write_strobe_n <= 1'b1;
                            shared_data_lines_oe <= 1'b0;
                            device_select_n <= 1'b0;
                            output_gate_n <= 1'b0;
                            cnt <= RACC_CNT;
                            state <= ST_RACC;
                        end
                    end
                end
                ST_SETUP: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        // select and strobe fall together: outputs stay off
                        device_select_n <= 1'b0;
                        write_strobe_n <= 1'b0;
                        cnt <= WHOLD_CNT;
                        state <= ST_WPULSE;
                    end
                end
                ST_WPULSE: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        // strobe rises first, ending write
                        write_strobe_n <= 1'b1;
                        cnt <= WREC_CNT;
                        state <= ST_WREC;
                    end
                end
                ST_WREC: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        device_select_n <= 1'b1;
                        low_byte_en_n <= 1'b1;
                        high_byte_en_n <= 1'b1;
                        shared_data_lines_oe <= 1'b0;
                        req_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_RACC: begin
                    // wait access time plus synchroniser delay
                    if (cnt > 0) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        cnt <= SYNC_CNT;
                        state <= ST_RDONE;
                    end
                end
                ST_RDONE: begin
                    if (cnt > 0) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        // disabled lanes read as zero
                        rsp_rdata <= rd_sync & lane_mask;
                        device_select_n <= 1'b1;
                        output_gate_n <= 1'b1;
                        low_byte_en_n <= 1'b1;
                        high_byte_en_n <= 1'b1;
                        req_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> dv/asbl_sram_model.sv
// Purpose: behavioural static ram on the host pins
// Assumes: pin levels only, no timing
// Notes: lane drive is reported, the bench resolves the bus
`timescale 1ns/1ps
`default_nettype none
module asbl_sram_model (
    // memory pins
    input wire logic [17:0] addr_lines,
    input wire logic device_select_n,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic low_byte_en_n,
    input wire logic high_byte_en_n,
    // data lanes
    input wire logic [15:0] bus,
    output logic [15:0] drv,
    output logic [1:0] drv_en
);
    logic [15:0] mem [0:262143];
    wire logic rd = !device_select_n && !output_gate_n && write_strobe_n;
    wire logic wr = !device_select_n && !write_strobe_n;
    assign drv_en = {2{rd}} & ~{high_byte_en_n, low_byte_en_n};
    assign drv = mem[addr_lines];
    always @* begin
        if (wr && !low_byte_en_n) begin
            mem[addr_lines][7:0] = bus[7:0];
        end
        if (wr && !high_byte_en_n) begin
            mem[addr_lines][15:8] = bus[15:8];
        end
    end
endmodule
`default_nettype wire

// >>> dv/asbl_host_chk.sv
// Purpose: pin protocol checker for asbl_host
// Assumes: default cycle counts
// Notes: bound from the bench
`timescale 1ns/1ps
`default_nettype none
module asbl_host_chk #(parameter ADDR_W = 18, parameter DATA_W = 16) (
    // all ports of asbl_host
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lane_en,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic [ADDR_W-1:0] addr_lines,
    input wire logic device_select_n,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic low_byte_en_n,
    input wire logic high_byte_en_n,
    input wire logic [DATA_W-1:0] shared_data_lines_i,
    input wire logic [DATA_W-1:0] shared_data_lines_o,
    input wire logic shared_data_lines_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic [1:0] lanes = ~{high_byte_en_n, low_byte_en_n};
    sequence s_take;
        req_valid && !req_ready && device_select_n && write_strobe_n && !shared_data_lines_oe;
    endsequence
    sequence s_wr;
        device_select_n ##1 !device_select_n && !write_strobe_n ##1 write_strobe_n
            ##1 device_select_n && req_ready && rsp_valid;
    endsequence
    sequence s_rd;
        (!device_select_n && !output_gate_n)[*6] ##1 (device_select_n && rsp_valid);
    endsequence
    property p_rd_no_drive; !output_gate_n |-> !shared_data_lines_oe; endproperty
    a_rd_no_drive: assert property (p_rd_no_drive) else $error("bus driven in read");
    property p_rd_strobe; !output_gate_n |-> write_strobe_n; endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read");
    property p_wr_pins;
        !write_strobe_n |-> output_gate_n && shared_data_lines_oe && !device_select_n;
    endproperty
    a_wr_pins: assert property (p_wr_pins) else $error("bad pins in write");
    property p_wr_setup; $fell(write_strobe_n) |-> $stable(addr_lines); endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("addr not set up");
    property p_wr_hold; $rose(write_strobe_n) |=> $stable(addr_lines); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("addr not held");
    property p_wr_take;
        s_take ##0 req_write |=> lanes == $past(req_lane_en) && addr_lines == $past(req_addr)
            && shared_data_lines_o == $past(req_wdata) && shared_data_lines_oe;
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write setup wrong");
    property p_wr_seq; s_take ##0 req_write |=> s_wr; endproperty
    a_wr_seq: assert property (p_wr_seq) else $error("write order wrong");
    property p_rd_seq;
        s_take ##0 !req_write |=> lanes == $past(req_lane_en)
            && addr_lines == $past(req_addr) ##0 s_rd;
    endproperty
    a_rd_seq: assert property (p_rd_seq) else $error("read order wrong");
endmodule
`default_nettype wire

// >>> dv/asbl_host_test.sv
// Purpose: self-checking bench for asbl_host
// Assumes: ram model on the far side
// Notes: random lanes, data and order over four addresses
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin mismatches++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module asbl_host_test;
    logic core_clk, rst, req_valid, req_write, req_ready, rsp_valid, oe, dsn, wsn, ogn, lbn, hbn;
    logic [17:0] req_addr, addr;
    logic [15:0] req_wdata, rsp_rdata, dout, shadow [logic [17:0]];
    logic [1:0] req_lane_en;
    logic [16:0] expq [$];
    logic [16:0] e;
    logic tog = 1'b0;
    logic [17:0] adr [4] = '{18'h0_0000, 18'h3_ffff, 18'h2_aaaa, 18'h1_5555};
    int mismatches = 0, samples_checked = 0, cyc = 0, seed, r;
    wire logic [15:0] drv, bus;
    wire logic [1:0] drv_en;
    wire logic [15:0] fill = tog ? 16'h5a5a : 16'ha5a5;
    assign bus[7:0] = oe ? dout[7:0] : drv_en[0] ? drv[7:0] : fill[7:0];
    assign bus[15:8] = oe ? dout[15:8] : drv_en[1] ? drv[15:8] : fill[15:8];
    asbl_host i_asbl_host (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_en(req_lane_en), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .addr_lines(addr), .device_select_n(dsn),
        .write_strobe_n(wsn), .output_gate_n(ogn), .low_byte_en_n(lbn),
        .high_byte_en_n(hbn), .shared_data_lines_i(bus), .shared_data_lines_o(dout),
        .shared_data_lines_oe(oe));
    asbl_sram_model i_asbl_sram_model (.addr_lines(addr), .device_select_n(dsn),
        .write_strobe_n(wsn), .output_gate_n(ogn), .low_byte_en_n(lbn),
        .high_byte_en_n(hbn), .bus(bus), .drv(drv), .drv_en(drv_en));
    task give_verdict;
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] l);
        int n;
        n = 0;
        @(negedge core_clk);
        {req_valid, req_write, req_addr, req_wdata, req_lane_en} = {1'b1, w, a, d, l};
        if (w && l[0]) shadow[a][7:0] = d[7:0];
        if (w && l[1]) shadow[a][15:8] = d[15:8];
        expq.push_back({!w, shadow[a] & {{8{l[1]}}, {8{l[0]}}}});
        do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 20);
        if (n >= 20) mismatches++;
        `CHK("req_ready_cycles", (w ? 3 : 6), n)
        req_valid = 1'b0;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        tog <= ~tog;
        if (++cyc == 5000) begin
            mismatches++;
            give_verdict();
        end
        if (rsp_valid === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[16]) `CHK("rsp_rdata", e[15:0], rsp_rdata)
        end else if (rsp_valid === 1'b1) begin
            `CHK("rsp_valid", 1'b0, rsp_valid)
        end
    end
    initial begin
        seed = 32'hc1bb;
        {rst, req_valid, req_write, req_addr, req_wdata, req_lane_en} = {1'b1, 38'h0};
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        foreach (adr[i]) op(1'b1, adr[i], 16'($random(seed)), 2'b11);
        for (int i = 0; i < 4; i++) op(1'b0, adr[1], 16'h0000, 2'(i));
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            op(r[2], adr[r[1:0]], r[31:16], r[4:3]);
        end
        repeat (10) @(negedge core_clk);
        `CHK("pending_notes", 0, expq.size())
        give_verdict();
    end
endmodule
bind asbl_host asbl_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_asbl_host_chk (.*);
`default_nettype wire
